// >>> logic/spm_defines.svh
// Constants for the sleep/idle power mode controller
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

`define SPM_ADDR_OSC_CTRL     8'h00
`define SPM_ADDR_PB_DIV       8'h04
`define SPM_ADDR_PB_EN        8'h08
`define SPM_ADDR_STOP_IDLE    8'h0C
`define SPM_ADDR_STATUS       8'h10
`define SPM_ADDR_CPU_PRIO     8'h14

`define SPM_SLEEP_SELECT_BIT  4
`define SPM_CLK_SRC_LSB       0
`define SPM_CLK_SRC_MSB       1
`define SPM_CPU_DIV_LSB       8
`define SPM_CPU_DIV_MSB       11
`define SPM_FAST_DIV_LSB      12
`define SPM_FAST_DIV_MSB      15

`define SPM_OSC_CTRL_RESET    32'h0000_0000
`define SPM_PB_DIV_RESET      32'h0000_0000
`define SPM_PB_EN_RESET       8'hFF
`define SPM_STOP_IDLE_RESET   8'h00

`define SPM_NUM_PB            8
`define SPM_DIV_W             4
`define SPM_PRIO_W            3

// Oscillator start-up waits after Sleep, in cycles of sys_clk
`define SPM_WAKE_PRIMARY      16'h0040
`define SPM_WAKE_LOW_POWER_RC_OSCILLATOR         16'h0010
`define SPM_WAKE_SECONDARY    16'h0100
`define SPM_WAKE_PLL          16'h1388

`define SPM_AXI_OKAY          2'b00
`define SPM_AXI_SLVERR        2'b10

`endif

// >>> logic/spm_pkg.sv
// Types for the sleep/idle power mode controller
package spm_pkg;
    typedef enum {
        SPM_RUN,
        SPM_IDLE,
        SPM_SLEEP,
        SPM_WAKE
    } spm_mode_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } spm_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } spm_axi_rsp_t;

    typedef struct packed {
        logic       wait_exec;
        logic       irq_valid;
        logic [2:0] irq_prio;
        logic       irq_runs_in_sleep;
        logic       wdt_timeout;
    } spm_core_in_t;
endpackage : spm_pkg

// >>> logic/spm_clk_div.sv
// One gated clock-enable divider, used for each peripheral bus and for the CPU clock
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_clk_div (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [3:0] div,
    output logic            tick
);
    import spm_pkg::*;

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } spm_div_state_t;

    spm_div_state_t state_reg;
    spm_div_state_t state_next;

    // A tick every div+1 cycles; div of zero gives full rate
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.cnt = 4'h0;
        end else if (state_reg.cnt >= div) begin
            state_next.cnt  = 4'h0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule : spm_clk_div

// >>> logic/spm_power_ctrl.sv
// Sleep/idle power mode controller with AXI4-Lite registers
// What this block does
// [R1] Running power cut by clock divide or source
// [R2] Each peripheral bus divided or switched off
// [R3] Sleep halts CPU and gates most clocks
// [R4] Sleep-capable peripherals keep clock and wake
// [R5] Sleep exit waits for chosen oscillator start-up
// [R6] Fail-safe clock monitor off during Sleep
// [R7] Brown-out detector stays on in Sleep
// [R8] Watchdog not cleared on Sleep entry
// [R9] Higher priority enabled interrupt ends Sleep
// [R10] Any reset ends Sleep or Idle
// [R11] Watchdog time-out wakes from Sleep
// [R12] Low priority interrupt moves Sleep to Idle
// [R13] Idle halts CPU, all clocks stay on; here the CPU clock tick is also gated in Idle
// [R14] Stop-in-idle bit stops that peripheral in Idle
// [R15] Wait with sleep-select clear enters Idle
// [R16] Higher priority interrupt ends Idle
// [R17] Watchdog time-out interrupt ends Idle
// [R18] Wait with sleep-select set enters Sleep
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_power_ctrl (
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    input  wire spm_pkg::spm_axi_req_t axi_req,
    output spm_pkg::spm_axi_rsp_t      axi_rsp,
    input  wire spm_pkg::spm_core_in_t core_in,
    input  wire logic [7:0]            pb_sleep_capable,
    output logic                       cpu_halt,
    output logic                       cpu_clk_tick,
    output logic [7:0]                 pb_clk_tick,
    output logic                       fast_pb_clk_tick,
    output logic [1:0]                 clk_src_sel,
    output logic                       fail_safe_clock_monitor_enable,
    output logic                       brownout_enable,
    output logic                       wdt_clear,
    output logic [1:0]                 power_mode
);
    import spm_pkg::*;

    typedef struct packed {
        spm_mode_t    mode;
        logic [15:0]  wake_cnt;
        logic [31:0]  osc_ctrl;
        logic [31:0]  pb_div;
        logic [7:0]   pb_en;
        logic [7:0]   stop_idle;
        logic [2:0]   cpu_prio;
        logic         aw_held;
        logic [7:0]   aw_addr;
        logic         w_held;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } spm_state_t;

    spm_state_t state_reg;
    spm_state_t state_next;

    logic        sleep_sel;
    logic        irq_higher;
    logic        in_sleep;
    logic [15:0] wake_len;
    logic [7:0]  pb_run;
    logic [31:0] wmask;
    logic        do_write;
    logic        do_read;

    assign sleep_sel  = state_reg.osc_ctrl[`SPM_SLEEP_SELECT_BIT];
    assign irq_higher = core_in.irq_valid && (core_in.irq_prio > state_reg.cpu_prio);
    assign in_sleep   = (state_reg.mode == SPM_SLEEP);
    assign wmask      = {{8{state_reg.w_strb[3]}}, {8{state_reg.w_strb[2]}},
                         {8{state_reg.w_strb[1]}}, {8{state_reg.w_strb[0]}}};
    assign do_write   = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    assign do_read    = axi_req.arvalid && !state_reg.rvalid;

    // Wait length follows the oscillator that software selected
    always_comb begin
        case (state_reg.osc_ctrl[`SPM_CLK_SRC_MSB:`SPM_CLK_SRC_LSB])
            2'd0:    wake_len = `SPM_WAKE_PRIMARY;
            2'd1:    wake_len = `SPM_WAKE_LOW_POWER_RC_OSCILLATOR;
            2'd2:    wake_len = `SPM_WAKE_SECONDARY;
            default: wake_len = `SPM_WAKE_PLL;
        endcase
    end

    always_comb begin
        state_next = state_reg;

        case (state_reg.mode)
            SPM_RUN: begin
                if (core_in.wait_exec && sleep_sel) begin
                    state_next.mode = SPM_SLEEP; // see [R18]
                end else if (core_in.wait_exec) begin
                    state_next.mode = SPM_IDLE; // see [R15]
                end
            end
            SPM_IDLE: begin
                // Low priority interrupts leave the core parked here
                if (irq_higher || core_in.wdt_timeout) begin
                    state_next.mode = SPM_RUN; // see [R16] see [R17]
                end
            end
            SPM_SLEEP: begin
                if ((irq_higher && core_in.irq_runs_in_sleep) || core_in.wdt_timeout) begin
                    state_next.mode     = SPM_WAKE; // see [R9] see [R11]
                    state_next.wake_cnt = wake_len; // see [R5]
                end else if (core_in.irq_valid && core_in.irq_runs_in_sleep) begin
                    state_next.mode = SPM_IDLE; // see [R12]
                end
            end
            SPM_WAKE: begin
                if (state_reg.wake_cnt <= 16'h0001) begin
                    state_next.mode     = SPM_RUN; // see [R5]
                    state_next.wake_cnt = 16'h0000;
                end else begin
                    state_next.wake_cnt = state_reg.wake_cnt - 16'h0001;
                end
            end
            default: state_next.mode = SPM_RUN;
        endcase

        // Write channel: address and data may arrive in either order
        if (axi_req.awvalid && !state_reg.aw_held) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !state_reg.w_held) begin
            state_next.w_held = 1'b1;
            state_next.w_data = axi_req.wdata;
            state_next.w_strb = axi_req.wstrb;
        end
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = `SPM_AXI_OKAY;
            case (state_reg.aw_addr)
                `SPM_ADDR_OSC_CTRL: state_next.osc_ctrl =
                    (state_reg.osc_ctrl & ~wmask) | (state_reg.w_data & wmask); // see [R1]
                `SPM_ADDR_PB_DIV: state_next.pb_div =
                    (state_reg.pb_div & ~wmask) | (state_reg.w_data & wmask); // see [R2]
                `SPM_ADDR_PB_EN: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.pb_en = state_reg.w_data[7:0]; // see [R2]
                    end
                end
                `SPM_ADDR_STOP_IDLE: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.stop_idle = state_reg.w_data[7:0]; // see [R14]
                    end
                end
                `SPM_ADDR_CPU_PRIO: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.cpu_prio = state_reg.w_data[2:0];
                    end
                end
                `SPM_ADDR_STATUS: ;
                default: state_next.bresp = `SPM_AXI_SLVERR;
            endcase
        end else if (state_reg.bvalid && axi_req.bready) begin
            state_next.bvalid = 1'b0;
        end

        if (do_read) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = `SPM_AXI_OKAY;
            case (axi_req.araddr)
                `SPM_ADDR_OSC_CTRL:  state_next.rdata = state_reg.osc_ctrl;
                `SPM_ADDR_PB_DIV:    state_next.rdata = state_reg.pb_div;
                `SPM_ADDR_PB_EN:     state_next.rdata = {24'h00_0000, state_reg.pb_en};
                `SPM_ADDR_STOP_IDLE: state_next.rdata = {24'h00_0000, state_reg.stop_idle};
                `SPM_ADDR_STATUS:    state_next.rdata = {16'h0000, state_reg.wake_cnt[15:2],
                                                         power_mode};
                `SPM_ADDR_CPU_PRIO:  state_next.rdata = {29'h0000_0000, state_reg.cpu_prio};
                default: begin
                    state_next.rdata = 32'h0000_0000;
                    state_next.rresp = `SPM_AXI_SLVERR;
                end
            endcase
        end else if (state_reg.rvalid && axi_req.rready) begin
            state_next.rvalid = 1'b0;
        end
    end

    // Asynchronous reset returns the core to running from any mode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg           <= '0;
            state_reg.mode      <= SPM_RUN; // see [R10]
            state_reg.osc_ctrl  <= `SPM_OSC_CTRL_RESET;
            state_reg.pb_div    <= `SPM_PB_DIV_RESET;
            state_reg.pb_en     <= `SPM_PB_EN_RESET;
            state_reg.stop_idle <= `SPM_STOP_IDLE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Peripheral clock gating per mode
    always_comb begin
        for (int i = 0; i < `SPM_NUM_PB; i++) begin
            case (state_reg.mode)
                SPM_RUN:   pb_run[i] = state_reg.pb_en[i]; // see [R2]
                SPM_IDLE:  pb_run[i] = state_reg.pb_en[i] && !state_reg.stop_idle[i]; // see [R14]
                SPM_SLEEP: pb_run[i] = state_reg.pb_en[i] && pb_sleep_capable[i]; // see [R3] see [R4]
                SPM_WAKE:  pb_run[i] = state_reg.pb_en[i] && pb_sleep_capable[i];
                default:   pb_run[i] = 1'b0;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SPM_NUM_PB; g++) begin : g_pb
            spm_clk_div u_div (
                .sys_clk (sys_clk),
                .reset_n (reset_n),
                .run     (pb_run[g]),
                .div     (state_reg.pb_div[g*`SPM_DIV_W +: `SPM_DIV_W]),
                .tick    (pb_clk_tick[g])
            );
        end
    endgenerate

    // CPU clock runs only when the core is out of every halted mode
    spm_clk_div u_cpu_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .run     (state_reg.mode == SPM_RUN), // see [R1] see [R13]
        .div     (state_reg.osc_ctrl[`SPM_CPU_DIV_MSB:`SPM_CPU_DIV_LSB]),
        .tick    (cpu_clk_tick)
    );

    // Fastest bus is kept running in Idle; gated in Sleep and during the wake wait
    spm_clk_div u_fast_div (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .run     (!in_sleep && state_reg.mode != SPM_WAKE), // see [R1] see [R13]
        .div     (state_reg.osc_ctrl[`SPM_FAST_DIV_MSB:`SPM_FAST_DIV_LSB]),
        .tick    (fast_pb_clk_tick)
    );

    assign cpu_halt        = (state_reg.mode != SPM_RUN); // see [R3] see [R13]
    assign clk_src_sel     = state_reg.osc_ctrl[`SPM_CLK_SRC_MSB:`SPM_CLK_SRC_LSB];
    assign fail_safe_clock_monitor_enable     = !in_sleep; // see [R6]
    assign brownout_enable = 1'b1; // see [R7]
    // Watchdog keeps its count across Sleep entry; never cleared here
    assign wdt_clear       = 1'b0; // see [R8]

    always_comb begin
        case (state_reg.mode)
            SPM_RUN:   power_mode = 2'd0;
            SPM_IDLE:  power_mode = 2'd1;
            SPM_SLEEP: power_mode = 2'd2;
            default:   power_mode = 2'd3;
        endcase
    end

    assign axi_rsp.awready = !state_reg.aw_held;
    assign axi_rsp.wready  = !state_reg.w_held;
    assign axi_rsp.bvalid  = state_reg.bvalid;
    assign axi_rsp.bresp   = state_reg.bresp;
    assign axi_rsp.arready = !state_reg.rvalid;
    assign axi_rsp.rvalid  = state_reg.rvalid;
    assign axi_rsp.rdata   = state_reg.rdata;
    assign axi_rsp.rresp   = state_reg.rresp;

    chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg.mode == SPM_RUN && core_in.wait_exec && sleep_sel) |=> power_mode == 2'd2)
        else $error("wait with sleep select did not enter sleep"); // see [R18]
    chk_idle_entry: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg.mode == SPM_RUN && core_in.wait_exec && !sleep_sel) |=> power_mode == 2'd1)
        else $error("wait without sleep select did not enter idle"); // see [R15]
    chk_idle_hold_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg.mode == SPM_IDLE && !irq_higher && !core_in.wdt_timeout) |=> cpu_halt)
        else $error("idle left without cause"); // see [R16]
    chk_idle_exit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg.mode == SPM_IDLE && core_in.wdt_timeout) |=> !cpu_halt)
        else $error("watchdog did not end idle"); // see [R17]
    chk_sleep_wake: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (in_sleep && core_in.wdt_timeout) |=> power_mode == 2'd3)
        else $error("watchdog did not wake from sleep"); // see [R11]
    chk_wake_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (in_sleep && core_in.wdt_timeout && clk_src_sel == 2'd1) |=> cpu_halt [*8])
        else $error("sleep exit did not wait for oscillator"); // see [R5]
    chk_fail_safe_clock_monitor_sleep: assert property (@(posedge sys_clk) disable iff (!reset_n)
        in_sleep |-> !fail_safe_clock_monitor_enable && brownout_enable)
        else $error("monitor state wrong in sleep"); // see [R6]
    chk_sleep_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (in_sleep && $past(in_sleep)) |-> !cpu_clk_tick && !fast_pb_clk_tick)
        else $error("clock ran in sleep"); // see [R3]
    chk_low_to_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (in_sleep && core_in.irq_valid && core_in.irq_runs_in_sleep && !irq_higher
         && !core_in.wdt_timeout) |=> power_mode == 2'd1 && cpu_halt)
        else $error("low priority interrupt did not move to idle"); // see [R12]
endmodule : spm_power_ctrl

// >>> tb/spm_core_model.sv
// Behavioural CPU core and interrupt controller facing the power controller
`timescale 1ns/1ps
module spm_core_model (
    input  wire logic             sys_clk,
    input  wire logic             cpu_halt,
    output spm_pkg::spm_core_in_t core_in
);
    import spm_pkg::*;

    initial begin
        core_in = '0;
    end

    // A halted core fetches nothing, so it never issues a wait while stopped
    task automatic exec_wait();
        core_in.wait_exec <= !cpu_halt;
        @(posedge sys_clk);
        core_in.wait_exec <= 1'b0;
    endtask : exec_wait

    task automatic wdt_pulse();
        core_in.wdt_timeout <= 1'b1;
        @(posedge sys_clk);
        core_in.wdt_timeout <= 1'b0;
    endtask : wdt_pulse

    // Request stays pending until the bench withdraws it, as if unserviced
    task automatic set_irq(input logic v, input logic [2:0] p, input logic s);
        core_in.irq_valid         <= v;
        core_in.irq_prio          <= p;
        core_in.irq_runs_in_sleep <= s;
        @(posedge sys_clk);
    endtask : set_irq
endmodule : spm_core_model

// >>> tb/test_spm_power_ctrl.sv
// Self-checking bench for the sleep/idle power mode controller
`timescale 1ns/1ps
`include "spm_defines.svh"
module test_spm_power_ctrl;
    import spm_pkg::*;
    logic         sys_clk;
    logic         reset_n;
    spm_axi_req_t axi_req;
    spm_axi_rsp_t axi_rsp;
    spm_core_in_t core_in;
    logic [7:0]   pb_sleep_capable;
    logic         cpu_halt;
    logic         cpu_clk_tick;
    logic [7:0]   pb_clk_tick;
    logic         fast_pb_clk_tick;
    logic [1:0]   clk_src_sel;
    logic         fail_safe_clock_monitor_enable;
    logic         brownout_enable;
    logic         wdt_clear;
    logic [1:0]   power_mode;
    int           error_cnt;
    int           cmp_count;
    // Four-state counters so an unknown tick shows up in the compare
    logic [31:0]  tk_cpu;
    logic [31:0]  tk_fast;
    logic [31:0]  tk_pb [8];
    int           n;
    int           wake_len [4];

    spm_power_ctrl dut_u (
        .sys_clk          (sys_clk),
        .reset_n          (reset_n),
        .axi_req          (axi_req),
        .axi_rsp          (axi_rsp),
        .core_in          (core_in),
        .pb_sleep_capable (pb_sleep_capable),
        .cpu_halt         (cpu_halt),
        .cpu_clk_tick     (cpu_clk_tick),
        .pb_clk_tick      (pb_clk_tick),
        .fast_pb_clk_tick (fast_pb_clk_tick),
        .clk_src_sel      (clk_src_sel),
        .fail_safe_clock_monitor_enable      (fail_safe_clock_monitor_enable),
        .brownout_enable  (brownout_enable),
        .wdt_clear        (wdt_clear),
        .power_mode       (power_mode)
    );

    spm_core_model core_u (
        .sys_clk  (sys_clk),
        .cpu_halt (cpu_halt),
        .core_in  (core_in)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        axi_req.awaddr  <= a;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid  <= 1'b1;
        axi_req.bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge sys_clk);
            if (!aw_ok && axi_rsp.awready === 1'b1) begin
                aw_ok = 1'b1;
                axi_req.awvalid <= 1'b0;
            end
            if (!w_ok && axi_rsp.wready === 1'b1) begin
                w_ok = 1'b1;
                axi_req.wvalid <= 1'b0;
            end
        end
        // bready stays high, so a following call only reassigns it the same value
        do @(posedge sys_clk); while (axi_rsp.bvalid !== 1'b1);
        check(axi_rsp.bresp, er);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
                            input logic [1:0] er);
        axi_req.araddr  <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready  <= 1'b1;
        do @(posedge sys_clk); while (axi_rsp.arready !== 1'b1);
        axi_req.arvalid <= 1'b0;
        do @(posedge sys_clk); while (axi_rsp.rvalid !== 1'b1);
        check(axi_rsp.rdata & m, ed);
        check(axi_rsp.rresp, er);
    endtask : axi_read

    // Windows are multiples of every divide used, so counts do not depend on phase
    task automatic count_ticks(input int c);
        tk_cpu = 0;
        tk_fast = 0;
        foreach (tk_pb[i]) tk_pb[i] = 0;
        repeat (c) begin
            @(posedge sys_clk);
            tk_cpu += cpu_clk_tick;
            tk_fast += fast_pb_clk_tick;
            foreach (tk_pb[i]) tk_pb[i] += pb_clk_tick[i];
        end
    endtask : count_ticks

    task automatic wait_mode(input logic [1:0] m);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (power_mode !== m && n < 6000);
        if (power_mode !== m) begin
            error_cnt++;
            $display("ERROR %0t: mode %0d not reached", $time, m);
        end
    endtask : wait_mode

    task automatic complete_run();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        #1_500_000;
        error_cnt++;
        complete_run();
    end

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        wake_len = '{`SPM_WAKE_PRIMARY, `SPM_WAKE_LOW_POWER_RC_OSCILLATOR, `SPM_WAKE_SECONDARY, `SPM_WAKE_PLL};
        axi_req = '0;
        reset_n = 1'b0;
        pb_sleep_capable = 8'h03;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        check(power_mode, 0);
        check(fail_safe_clock_monitor_enable, 1);
        axi_read(`SPM_ADDR_OSC_CTRL, 32'h0000_0000, 32'hffff_ffff, `SPM_AXI_OKAY);
        axi_read(`SPM_ADDR_PB_DIV, 32'h0000_0000, 32'hffff_ffff, `SPM_AXI_OKAY);
        axi_read(`SPM_ADDR_PB_EN, 32'h0000_00ff, 32'hffff_ffff, `SPM_AXI_OKAY);
        axi_read(`SPM_ADDR_STOP_IDLE, 32'h0000_0000, 32'hffff_ffff, `SPM_AXI_OKAY);
        axi_read(8'h20, 32'h0000_0000, 32'hffff_ffff, `SPM_AXI_SLVERR);
        axi_write(8'h20, 32'h0000_ffff, `SPM_AXI_SLVERR);
        // CPU divide 3, fastest bus divide 2, low-power source
        axi_write(`SPM_ADDR_OSC_CTRL, 32'h0000_2301, `SPM_AXI_OKAY);
        check(clk_src_sel, 1);
        axi_write(`SPM_ADDR_PB_DIV, 32'h0000_0002, `SPM_AXI_OKAY);
        axi_write(`SPM_ADDR_PB_EN, 32'h0000_00fd, `SPM_AXI_OKAY);
        count_ticks(24);
        check(tk_cpu, 6);
        check(tk_fast, 8);
        check(tk_pb[0], 8);
        check(tk_pb[1], 0);
        check(tk_pb[2], 24);
        axi_write(`SPM_ADDR_STOP_IDLE, 32'h0000_0004, `SPM_AXI_OKAY);
        axi_write(`SPM_ADDR_CPU_PRIO, 32'h0000_0003, `SPM_AXI_OKAY);
        core_u.exec_wait();
        wait_mode(1);
        check(n, 1);
        check(cpu_halt, 1);
        axi_read(`SPM_ADDR_STATUS, 32'h0000_0001, 32'h0000_0003, `SPM_AXI_OKAY);
        count_ticks(24);
        check(tk_cpu, 0);
        check(tk_fast, 8);
        check(tk_pb[0], 8);
        check(tk_pb[2], 0);
        core_u.set_irq(1'b1, 3'd3, 1'b0);
        repeat (8) @(posedge sys_clk);
        check(power_mode, 1);
        core_u.set_irq(1'b1, 3'd4, 1'b0);
        wait_mode(0);
        check(n, 1);
        core_u.set_irq(1'b0, 3'd0, 1'b0);
        core_u.exec_wait();
        wait_mode(1);
        core_u.wdt_pulse();
        wait_mode(0);
        check(n, 1);
        // Sleep select set: bus 0 is enabled and sleep-capable, bus 1 capable but off
        axi_write(`SPM_ADDR_OSC_CTRL, 32'h0000_2311, `SPM_AXI_OKAY);
        core_u.exec_wait();
        wait_mode(2);
        check(n, 1);
        check(cpu_halt, 1);
        check(fail_safe_clock_monitor_enable, 0);
        check(brownout_enable, 1);
        check(wdt_clear, 0);
        count_ticks(24);
        check(tk_cpu, 0);
        check(tk_fast, 0);
        check(tk_pb[0], 8);
        check(tk_pb[1] + tk_pb[2], 0);
        core_u.set_irq(1'b1, 3'd5, 1'b1);
        wait_mode(3);
        check(n, 1);
        wait_mode(0);
        core_u.set_irq(1'b0, 3'd0, 1'b0);
        core_u.exec_wait();
        wait_mode(2);
        core_u.set_irq(1'b1, 3'd2, 1'b1);
        wait_mode(1);
        check(n, 1);
        check(cpu_halt, 1);
        count_ticks(24);
        check(tk_pb[3], 24);
        core_u.set_irq(1'b1, 3'd6, 1'b1);
        wait_mode(0);
        check(n, 1);
        core_u.set_irq(1'b0, 3'd0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            axi_write(`SPM_ADDR_OSC_CTRL, 32'h0000_2310 | s, `SPM_AXI_OKAY);
            core_u.exec_wait();
            wait_mode(2);
            core_u.wdt_pulse();
            wait_mode(3);
            check(n, 1);
            wait_mode(0);
            check(n, wake_len[s]);
        end
        core_u.exec_wait();
        wait_mode(2);
        reset_n <= 1'b0;
        @(posedge sys_clk);
        check(power_mode, 0);
        check(cpu_halt, 0);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        axi_read(`SPM_ADDR_OSC_CTRL, 32'h0000_0000, 32'hffff_ffff, `SPM_AXI_OKAY);
        complete_run();
    end
endmodule : test_spm_power_ctrl
